/* File: hdl/mmw_pkg.sv */
// Package of constants and types for the multiple-write request builder
package mmw_pkg;
   // Clock and timing
   localparam longint CLK_HZ = 100000000;
   localparam longint TIMEOUT_MS = 500;
   localparam longint ACK_WAIT_MS = 100;
   localparam longint TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
   localparam longint ACK_WAIT_CYC = ACK_WAIT_MS * (CLK_HZ / 1000);
   // Register byte offsets
   localparam logic [11:0] OFF_CTRL = 12'h000;
   localparam logic [11:0] OFF_CFG = 12'h004;
   localparam logic [11:0] OFF_REQ0 = 12'h008;
   localparam logic [11:0] OFF_REQ1 = 12'h00c;
   localparam logic [11:0] OFF_TIMEOUT = 12'h010;
   localparam logic [11:0] OFF_RESULT = 12'h014;
   localparam logic [11:0] OFF_IRQ_STAT = 12'h018;
   localparam logic [11:0] OFF_IRQ_MASK = 12'h01c;
   localparam logic [1:0] PAYLOAD_WIN = 2'h1;
   // Field positions
   localparam int CTRL_START_BIT = 0;
   localparam int CFG_ROLE_BIT = 8;
   localparam int CFG_MODE_BIT = 9;
   localparam int RES_DONE_BIT = 0;
   localparam int RES_ERR_BIT = 1;
   localparam int RES_BUSY_BIT = 2;
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_ERR_BIT = 1;
   // Reset values
   localparam logic [7:0] OWN_STATION_RST = 8'h01;
   localparam logic [1:0] IRQ_MASK_RST = 2'h0;
   // Frame layout
   localparam logic [9:0] HDR_BYTES = 10'h007;
   localparam logic [8:0] MAX_BYTES = 9'h100;
   localparam logic [7:0] FUNCTION_CODE_IN_COILS = 8'h0f;
   localparam logic [7:0] FUNCTION_CODE_IN_REGS = 8'h10;
   // Result codes
   localparam logic [7:0] ST_OK = 8'h00;
   localparam logic [7:0] ST_ILL_FUNCTION_CODE_IN = 8'h01;
   localparam logic [7:0] ST_ACK = 8'h05;
   localparam logic [7:0] ST_BUSY = 8'h06;
   localparam logic [7:0] ST_TIMEOUT = 8'h07;
   localparam logic [7:0] ST_NUMBER = 8'h08;
   localparam logic [7:0] ST_PARAM = 8'h09;
   localparam logic [7:0] ST_STATION = 8'h0a;

   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_CHECK = 3'b001,
      S_FETCH = 3'b010,
      S_LOAD = 3'b011,
      S_SEND = 3'b100,
      S_WAIT = 3'b101,
      S_ACKWAIT = 3'b110
   } mmw_state_t;
endpackage

/* File: hdl/mmw_payload_ram.sv */
// Payload byte memory: one write port, one registered read port
module mmw_payload_ram #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 256,
   parameter int AW = $clog2(DEPTH)
) (
   // Clock, reset, enable
   input logic pclk,
   input logic presetn,
   input logic pclk_en,
   // Write port
   input logic wr_en,
   input logic [AW-1:0] wr_addr,
   input logic [WIDTH-1:0] wr_data,
   // Read port
   input logic [AW-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge pclk) begin
      if (pclk_en && wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_data <= '0;
      end else if (pclk_en) begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule

/* File: hdl/mmw_master.sv */
// Multiple-write request builder (coils and holding registers) with APB registers
// Summary of operation
// - Function sixteen writes consecutive words from start
// - Words in order, higher-index byte first
// - Coil bits beyond quantity are ignored
// - Start offset is zero-based, no table digit
// - Quantity high and low bytes sent as count
// - Exceptions one to four reported as codes
// - Acknowledge records five, waits, no re-request
// - Busy records six and re-sends request
// - No response within limit ends with seven
// - Size zero, over 256 or array: eight
// - Quantity and byte count mismatch: eight
// - Unsuitable port configuration gives nine
// - Target equal to own station gives ten
// - Coils packed from bit zero, zero fill
// - Done or error held until next start
module mmw_master #(
   parameter int DEPTH = 256,
   parameter logic [31:0] TIMEOUT_RST = 32'(mmw_pkg::TIMEOUT_CYC),
   parameter logic [31:0] ACK_WAIT = 32'(mmw_pkg::ACK_WAIT_CYC)
) (
   // Clock, reset, enable
   input logic pclk,
   input logic presetn,
   input logic pclk_en,
   // APB slave
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [11:0] paddr,
   input logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Request byte stream towards the serial layer
   output logic tx_valid,
   output logic [7:0] tx_data,
   output logic tx_last,
   input logic tx_ready,
   // Response from the serial layer
   input logic rsp_valid,
   input logic rsp_exception,
   input logic [7:0] rsp_code,
   // Result
   output logic done_flag,
   output logic err_flag,
   output logic [7:0] status_code,
   output logic irq
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      mmw_pkg::mmw_state_t st;
      logic [7:0] own_station;
      logic master_role;
      logic mode_ok;
      logic [7:0] target_station_number;
      logic [7:0] function_code_in;
      logic [7:0] start_offset_high;
      logic [7:0] start_offset_low;
      logic [7:0] item_count_high;
      logic [7:0] item_count_low;
      logic [8:0] payload_byte_count;
      logic [31:0] timeout;
      logic done;
      logic err;
      logic [7:0] status;
      logic [1:0] irq_stat;
      logic [1:0] irq_mask;
      logic [9:0] pos;
      logic [31:0] timer;
      logic [7:0] tx_data;
      logic [31:0] prdata;
   } mmw_regs_t;

   mmw_regs_t r;
   mmw_regs_t next_r;

   logic apb_wr;
   logic apb_rd_setup;
   logic in_payload;
   logic unmapped;
   logic busy;
   logic is_coil;
   logic is_reg;
   logic [15:0] qty;
   logic [9:0] pay_idx;
   logic last_byte;
   logic size_bad;
   logic match_bad;
   logic [AW-1:0] rd_addr;
   logic [7:0] rd_data;
   logic [7:0] coil_mask;
   logic done_set;
   logic err_set;
   logic [31:0] rd_val;

   assign apb_wr = psel && penable && pwrite;
   assign apb_rd_setup = psel && !penable && !pwrite;
   assign in_payload = paddr[11:10] == mmw_pkg::PAYLOAD_WIN;
   assign busy = r.st != mmw_pkg::S_IDLE;
   assign is_coil = r.function_code_in == mmw_pkg::FUNCTION_CODE_IN_COILS;
   assign is_reg = r.function_code_in == mmw_pkg::FUNCTION_CODE_IN_REGS;
   assign qty = {r.item_count_high, r.item_count_low};
   assign pay_idx = r.pos - mmw_pkg::HDR_BYTES;
   assign last_byte = r.pos == (mmw_pkg::HDR_BYTES - 10'h001 + {1'b0, r.payload_byte_count});
   // Words go out high-index byte first, so the byte index is flipped in its pair
   assign rd_addr = is_reg ? AW'(pay_idx ^ 10'h001) : AW'(pay_idx);
   assign size_bad = (r.payload_byte_count == 9'h000)
      || (r.payload_byte_count > mmw_pkg::MAX_BYTES)
      || (32'(r.payload_byte_count) > 32'(DEPTH));
   assign match_bad = is_coil
      ? ({8'h00, r.payload_byte_count} != ((17'(qty) + 17'h00007) >> 3))
      : ({8'h00, r.payload_byte_count} != {qty, 1'b0});
   // Quantity is bound to the byte count, so the final coil byte keeps qty mod 8 bits, or all 8 when that is zero
   assign coil_mask = (qty[2:0] == 3'h0) ? 8'hff : 8'((8'h01 << qty[2:0]) - 8'h01);

   always_comb begin
      unmapped = 1'b0;
      rd_val = 32'h0000_0000;
      if (in_payload) begin
         // Payload is write-only; reads return zero
         rd_val = 32'h0000_0000;
      end else begin
         unique case (paddr)
            mmw_pkg::OFF_CTRL: rd_val = 32'h0000_0000;
            mmw_pkg::OFF_CFG: rd_val = {22'h0, r.mode_ok, r.master_role, r.own_station};
            mmw_pkg::OFF_REQ0: rd_val = {r.start_offset_low, r.start_offset_high,
                                          r.function_code_in, r.target_station_number};
            mmw_pkg::OFF_REQ1: rd_val = {7'h00, r.payload_byte_count,
                                          r.item_count_low, r.item_count_high};
            mmw_pkg::OFF_TIMEOUT: rd_val = r.timeout;
            mmw_pkg::OFF_RESULT: rd_val = {16'h0000, r.status, 5'h00, busy, r.err, r.done};
            mmw_pkg::OFF_IRQ_STAT: rd_val = {30'h0, r.irq_stat};
            mmw_pkg::OFF_IRQ_MASK: rd_val = {30'h0, r.irq_mask};
            default: unmapped = 1'b1;
         endcase
      end
   end

   always_comb begin
      next_r = r;
      done_set = 1'b0;
      err_set = 1'b0;
      if (apb_rd_setup) begin
         next_r.prdata = rd_val;
      end
      // Request registers are locked while a transaction runs
      if (apb_wr && !busy && !in_payload) begin
         unique case (paddr)
            mmw_pkg::OFF_CFG: begin
               next_r.own_station = pwdata[7:0];
               next_r.master_role = pwdata[mmw_pkg::CFG_ROLE_BIT];
               next_r.mode_ok = pwdata[mmw_pkg::CFG_MODE_BIT];
            end
            mmw_pkg::OFF_REQ0: begin
               next_r.target_station_number = pwdata[7:0];
               next_r.function_code_in = pwdata[15:8];
               next_r.start_offset_high = pwdata[23:16];
               next_r.start_offset_low = pwdata[31:24];
            end
            mmw_pkg::OFF_REQ1: begin
               next_r.item_count_high = pwdata[7:0];
               next_r.item_count_low = pwdata[15:8];
               next_r.payload_byte_count = pwdata[24:16];
            end
            mmw_pkg::OFF_TIMEOUT: next_r.timeout = pwdata;
            mmw_pkg::OFF_CTRL: begin
               if (pwdata[mmw_pkg::CTRL_START_BIT]) begin
                  next_r.done = 1'b0;
                  next_r.err = 1'b0;
                  next_r.status = mmw_pkg::ST_OK;
                  next_r.st = mmw_pkg::S_CHECK;
               end
            end
            default: ;
         endcase
      end
      if (apb_wr && paddr == mmw_pkg::OFF_IRQ_MASK) begin
         next_r.irq_mask = pwdata[1:0];
      end
      if (apb_wr && paddr == mmw_pkg::OFF_IRQ_STAT) begin
         next_r.irq_stat = r.irq_stat & ~pwdata[1:0];
      end

      unique case (r.st)
         mmw_pkg::S_IDLE: ;
         mmw_pkg::S_CHECK: begin
            next_r.pos = 10'h000;
            next_r.st = mmw_pkg::S_IDLE;
            err_set = 1'b1;
            if (!(r.master_role && r.mode_ok)) begin
               next_r.status = mmw_pkg::ST_PARAM;
            end else if (r.target_station_number == r.own_station) begin
               next_r.status = mmw_pkg::ST_STATION;
            end else if (!is_coil && !is_reg) begin
               next_r.status = mmw_pkg::ST_ILL_FUNCTION_CODE_IN;
            end else if (size_bad || match_bad) begin
               next_r.status = mmw_pkg::ST_NUMBER;
            end else begin
               err_set = 1'b0;
               next_r.st = mmw_pkg::S_FETCH;
            end
         end
         mmw_pkg::S_FETCH: next_r.st = mmw_pkg::S_LOAD;
         mmw_pkg::S_LOAD: begin
            unique case (r.pos)
               10'h000: next_r.tx_data = r.target_station_number;
               10'h001: next_r.tx_data = r.function_code_in;
               10'h002: next_r.tx_data = r.start_offset_high;
               10'h003: next_r.tx_data = r.start_offset_low;
               10'h004: next_r.tx_data = r.item_count_high;
               10'h005: next_r.tx_data = r.item_count_low;
               10'h006: next_r.tx_data = r.payload_byte_count[7:0];
               default: begin
                  if (is_coil && last_byte) begin
                     next_r.tx_data = rd_data & coil_mask;
                  end else begin
                     next_r.tx_data = rd_data;
                  end
               end
            endcase
            next_r.st = mmw_pkg::S_SEND;
         end
         mmw_pkg::S_SEND: begin
            if (tx_ready) begin
               next_r.pos = r.pos + 10'h001;
               next_r.timer = 32'h0000_0000;
               next_r.st = last_byte ? mmw_pkg::S_WAIT : mmw_pkg::S_FETCH;
            end
         end
         mmw_pkg::S_WAIT: begin
            next_r.timer = r.timer + 32'h0000_0001;
            if (rsp_valid) begin
               next_r.timer = 32'h0000_0000;
               if (!rsp_exception) begin
                  next_r.st = mmw_pkg::S_IDLE;
                  next_r.done = 1'b1;
                  done_set = 1'b1;
               end else if (rsp_code == mmw_pkg::ST_ACK) begin
                  next_r.status = mmw_pkg::ST_ACK;
                  next_r.st = mmw_pkg::S_ACKWAIT;
               end else if (rsp_code == mmw_pkg::ST_BUSY) begin
                  next_r.status = mmw_pkg::ST_BUSY;
                  next_r.pos = 10'h000;
                  next_r.st = mmw_pkg::S_FETCH;
               end else begin
                  next_r.status = rsp_code;
                  next_r.st = mmw_pkg::S_IDLE;
                  err_set = 1'b1;
               end
            end else if (r.timer >= r.timeout) begin
               next_r.status = mmw_pkg::ST_TIMEOUT;
               next_r.st = mmw_pkg::S_IDLE;
               err_set = 1'b1;
            end
         end
         mmw_pkg::S_ACKWAIT: begin
            // The slave is still working on the request; stay quiet, then give up
            next_r.timer = r.timer + 32'h0000_0001;
            if (r.timer >= ACK_WAIT) begin
               next_r.st = mmw_pkg::S_IDLE;
               err_set = 1'b1;
            end
         end
         default: next_r.st = mmw_pkg::S_IDLE;
      endcase
      if (err_set) begin
         next_r.err = 1'b1;
      end
      // Hardware set wins over a software clear in the same cycle
      next_r.irq_stat[mmw_pkg::IRQ_DONE_BIT] = next_r.irq_stat[mmw_pkg::IRQ_DONE_BIT] | done_set;
      next_r.irq_stat[mmw_pkg::IRQ_ERR_BIT] = next_r.irq_stat[mmw_pkg::IRQ_ERR_BIT] | err_set;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '{st: mmw_pkg::S_IDLE, own_station: mmw_pkg::OWN_STATION_RST,
                timeout: TIMEOUT_RST, irq_mask: mmw_pkg::IRQ_MASK_RST, default: '0};
      end else if (pclk_en) begin
         r <= next_r;
      end
   end

   mmw_payload_ram #(
      .WIDTH(8),
      .DEPTH(DEPTH),
      .AW(AW)
   ) u_ram (
      .pclk(pclk),
      .presetn(presetn),
      .pclk_en(pclk_en),
      .wr_en(apb_wr && in_payload && !busy),
      .wr_addr(paddr[AW+1:2]),
      .wr_data(pwdata[7:0]),
      .rd_addr(rd_addr),
      .rd_data(rd_data)
   );

   assign pready = 1'b1;
   assign pslverr = psel && penable && unmapped;
   assign prdata = r.prdata;
   assign tx_valid = r.st == mmw_pkg::S_SEND;
   assign tx_data = r.tx_data;
   assign tx_last = tx_valid && last_byte;
   assign done_flag = r.done;
   assign err_flag = r.err;
   assign status_code = r.status;
   assign irq = |(r.irq_stat & r.irq_mask);

   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn || !pclk_en);

   logic chk_ok;
   assign chk_ok = r.st == mmw_pkg::S_CHECK && r.master_role && r.mode_ok;

   sequence seq_byte_cycle;
      (r.st == mmw_pkg::S_FETCH) ##1 (r.st == mmw_pkg::S_LOAD) ##1 tx_valid;
   endsequence
   sequence seq_reject;
      err_flag ##1 (!tx_valid)[*3];
   endsequence

   AST_REG_SWAP: assert property (r.st == mmw_pkg::S_FETCH && is_reg && r.pos >= 10'd7
      |-> rd_addr[0] != pay_idx[0] && rd_addr[AW-1:1] == pay_idx[AW-1:1])
      else $error("word byte order wrong");
   AST_FETCH_TO_SEND: assert property (r.st == mmw_pkg::S_FETCH |-> seq_byte_cycle)
      else $error("byte not presented two cycles after fetch");
   AST_COIL_ZERO_FILL: assert property (r.st == mmw_pkg::S_LOAD && is_coil && last_byte
      && r.pos >= 10'd7 && qty[2:0] != 3'h0 |=> (tx_data >> qty[2:0]) == 8'h00)
      else $error("coil fill bits not zero");
   AST_COUNT_BYTES: assert property (r.st == mmw_pkg::S_LOAD && r.pos == 10'd4
      |=> tx_valid && tx_data == r.item_count_high) else $error("count byte wrong");
   AST_OFFSET_LOW: assert property (r.st == mmw_pkg::S_LOAD && r.pos == 10'd3
      |=> tx_data == r.start_offset_low) else $error("offset byte wrong");
   AST_EXC_CODE: assert property (r.st == mmw_pkg::S_WAIT && rsp_valid && rsp_exception
      && rsp_code >= 8'h01 && rsp_code <= 8'h04 |=> err_flag && status_code == $past(rsp_code))
      else $error("exception code not reported");
   AST_ACK: assert property (r.st == mmw_pkg::S_WAIT && rsp_valid && rsp_exception
      && rsp_code == 8'h05 |=> status_code == 8'h05 && !tx_valid && !err_flag
      ##1 !tx_valid) else $error("acknowledge not handled");
   AST_BUSY: assert property (r.st == mmw_pkg::S_WAIT && rsp_valid && rsp_exception
      && rsp_code == 8'h06 |=> status_code == 8'h06 ##2 tx_valid && tx_data == $past(
      r.target_station_number, 3)) else $error("busy did not resend");
   AST_TIMEOUT: assert property (r.st == mmw_pkg::S_WAIT && !rsp_valid
      && r.timer >= r.timeout |=> err_flag && status_code == 8'h07)
      else $error("timeout not reported");
   AST_SIZE: assert property (chk_ok && r.target_station_number != r.own_station
      && (is_coil || is_reg) && size_bad |=> status_code == 8'h08 ##0 seq_reject)
      else $error("size error missed");
   AST_MATCH: assert property (chk_ok && r.target_station_number != r.own_station
      && (is_coil || is_reg) && match_bad |=> status_code == 8'h08 && err_flag)
      else $error("count mismatch missed");
   AST_PARAM: assert property (r.st == mmw_pkg::S_CHECK && !(r.master_role && r.mode_ok)
      |=> status_code == 8'h09 && err_flag) else $error("parameter error missed");
   AST_STATION: assert property (chk_ok && r.target_station_number == r.own_station
      |=> status_code == 8'h0a ##0 seq_reject) else $error("station error missed");
   AST_HOLD: assert property (!busy && !(apb_wr && paddr == mmw_pkg::OFF_CTRL)
      |=> done_flag == $past(done_flag) && err_flag == $past(err_flag))
      else $error("result changed while idle");
endmodule

/* File: dv/mmw_slave_model.sv */
// Behavioural far-side station: takes request bytes and answers as commanded
module mmw_slave_model (
   // Clock and reset
   input logic pclk,
   input logic presetn,
   // Request byte stream
   input logic tx_valid,
   input logic [7:0] tx_data,
   input logic tx_last,
   output logic tx_ready,
   // Response
   output logic rsp_valid,
   output logic rsp_exception,
   output logic [7:0] rsp_code,
   // Control: 0 ok, 1 exception, 2 silent, 3 busy once then ok
   input logic [1:0] rsp_mode,
   input logic [7:0] exc_code,
   input logic slow
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] rx_q[$];
   int wait_cnt;
   logic busy_sent;
   logic fire;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_exception <= 1'b1;
         rsp_code <= 8'ha5;
         wait_cnt = 0;
         busy_sent = 1'b0;
      end else begin
         fire = (wait_cnt == 1) && (rsp_mode != 2'd2);
         // Slow mode drops tx_ready every other cycle to exercise the stall path
         tx_ready <= slow ? ~tx_ready : 1'b1;
         rsp_valid <= fire;
         if (wait_cnt > 0) wait_cnt = wait_cnt - 1;
         if (tx_valid && tx_ready) begin
            rx_q.push_back(tx_data);
            if (tx_last) wait_cnt = 6;
         end
         if (fire) begin
            rsp_exception <= (rsp_mode == 2'd1) || (rsp_mode == 2'd3 && !busy_sent);
            rsp_code <= (rsp_mode == 2'd1) ? exc_code : 8'h06;
            busy_sent = busy_sent || (rsp_mode == 2'd3);
         end else if (rsp_valid) begin
            // Fields mean nothing after the pulse, so nothing may rely on them
            rsp_exception <= ~rsp_exception;
            rsp_code <= ~rsp_code;
         end
         if (rsp_mode != 2'd3) busy_sent = 1'b0;
      end
   end
endmodule

/* File: dv/test_modbus_multi_write_master.sv */
// Self-checking bench for the multiple-write request builder
module test_modbus_multi_write_master;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] RG0 = 32'h0100_1011;
   localparam logic [31:0] RG1 = 32'h0004_0200;
   localparam logic [31:0] CL0 = 32'h1300_0f11;
   localparam logic [31:0] CL1 = 32'h0002_0a00;
   localparam logic [31:0] RJ0 [6] = '{RG0, 32'h0100_1001, 32'h0100_0311, RG0, RG0, RG0};
   localparam logic [31:0] RJ1 [6] = '{RG1, RG1, RG1, 32'h0, 32'h0102_8100, 32'h0003_0200};
   localparam logic [7:0] RJS [6] = '{8'h09, 8'h0a, 8'h01, 8'h08, 8'h08, 8'h08};
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_seen;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic tx_valid, tx_last, tx_ready, rsp_valid, rsp_exception, slow;
   logic done_flag, err_flag, irq;
   logic [7:0] tx_data, rsp_code, exc_code, status_code;
   logic [1:0] rsp_mode;
   logic [7:0] exp_q[$];
   logic [7:0] pay[$];
   int num_errors, num_checks, cycles;

   mmw_master #(.DEPTH(256), .TIMEOUT_RST(32'd200), .ACK_WAIT(32'd20)) i_mmw_master (
      .pclk(pclk), .presetn(presetn), .pclk_en(1'b1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
      .tx_ready(tx_ready), .rsp_valid(rsp_valid), .rsp_exception(rsp_exception),
      .rsp_code(rsp_code), .done_flag(done_flag), .err_flag(err_flag),
      .status_code(status_code), .irq(irq));
   mmw_slave_model u_slave (
      .pclk(pclk), .presetn(presetn), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_last(tx_last), .tx_ready(tx_ready), .rsp_valid(rsp_valid),
      .rsp_exception(rsp_exception), .rsp_code(rsp_code), .rsp_mode(rsp_mode),
      .exc_code(exc_code), .slow(slow));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         num_errors++;
         $display("[FAIL] run length expected below 40000 seen %0d", cycles);
         complete_run();
      end
   end

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err_seen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic run(input logic [31:0] r0, input logic [31:0] r1);
      foreach (pay[i]) apb(1'b1, 12'h400 + 12'(4 * i), {24'h0, pay[i]});
      apb(1'b1, mmw_pkg::OFF_REQ0, r0);
      apb(1'b1, mmw_pkg::OFF_REQ1, r1);
      u_slave.rx_q.delete();
      apb(1'b1, mmw_pkg::OFF_CTRL, 32'h1);
      repeat (2) @(posedge pclk);
      while (done_flag !== 1'b1 && err_flag !== 1'b1) @(posedge pclk);
   endtask

   task automatic res(input logic dn, input logic er, input logic [7:0] st);
      chk("done_flag", {31'h0, dn}, {31'h0, done_flag});
      chk("err_flag", {31'h0, er}, {31'h0, err_flag});
      chk("status_code", {24'h0, st}, {24'h0, status_code});
      apb(1'b0, mmw_pkg::OFF_RESULT, 32'h0);
      chk("result register", {16'h0, st, 6'h0, er, dn}, rd);
   endtask

   task automatic chk_stream();
      chk("bytes sent", 32'(exp_q.size()), 32'(u_slave.rx_q.size()));
      foreach (exp_q[i]) begin
         if (i < u_slave.rx_q.size()) begin
            chk("request byte", {24'h0, exp_q[i]}, {24'h0, u_slave.rx_q[i]});
         end
      end
   endtask

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      rsp_mode = 2'd0;
      exc_code = 8'h00;
      slow = 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, mmw_pkg::OFF_CFG, 32'h0);
      chk("cfg reset", 32'h1, rd);
      apb(1'b0, mmw_pkg::OFF_TIMEOUT, 32'h0);
      chk("timeout reset", 32'd200, rd);
      res(1'b0, 1'b0, 8'h00);
      apb(1'b0, 12'h0f0, 32'h0);
      chk("unmapped slverr", 32'h1, {31'h0, err_seen});
      $display("test reset values done");
      // Rejections must leave the stream silent
      for (int k = 0; k < 6; k++) begin
         if (k == 1) apb(1'b1, mmw_pkg::OFF_CFG, 32'h301);
         run(RJ0[k], RJ1[k]);
         res(1'b0, 1'b1, RJS[k]);
         chk("rejected bytes", 32'h0, 32'(u_slave.rx_q.size()));
      end
      $display("test request checks done");
      pay = '{8'h0a, 8'h00, 8'h02, 8'h01};
      slow <= 1'b1;
      run(RG0, RG1);
      exp_q = '{8'h11, 8'h10, 8'h00, 8'h01, 8'h00, 8'h02, 8'h04, 8'h00, 8'h0a, 8'h01, 8'h02};
      chk_stream();
      res(1'b1, 1'b0, 8'h00);
      repeat (30) @(posedge pclk);
      res(1'b1, 1'b0, 8'h00);
      $display("test register write done");
      slow <= 1'b0;
      pay = '{8'hcd, 8'h81};
      run(CL0, CL1);
      exp_q = '{8'h11, 8'h0f, 8'h00, 8'h13, 8'h00, 8'h0a, 8'h02, 8'hcd, 8'h01};
      chk_stream();
      res(1'b1, 1'b0, 8'h00);
      $display("test coil write done");
      rsp_mode <= 2'd1;
      for (int c = 1; c < 5; c++) begin
         exc_code <= 8'(c);
         run(CL0, CL1);
         res(1'b0, 1'b1, 8'(c));
      end
      $display("test exceptions done");
      exc_code <= 8'h05;
      run(CL0, CL1);
      chk_stream();
      res(1'b0, 1'b1, 8'h05);
      rsp_mode <= 2'd3;
      run(CL0, CL1);
      exp_q = {exp_q, exp_q};
      chk_stream();
      // The busy code stays on record after the retry succeeds
      res(1'b1, 1'b0, 8'h06);
      rsp_mode <= 2'd2;
      run(CL0, CL1);
      res(1'b0, 1'b1, 8'h07);
      $display("test slave answers done");
      @(posedge pclk);
      chk("irq while masked", 32'h0, {31'h0, irq});
      apb(1'b1, mmw_pkg::OFF_IRQ_MASK, 32'h3);
      @(posedge pclk);
      chk("irq unmasked", 32'h1, {31'h0, irq});
      apb(1'b0, mmw_pkg::OFF_IRQ_STAT, 32'h0);
      chk("irq status", 32'h3, rd);
      apb(1'b1, mmw_pkg::OFF_IRQ_STAT, 32'h3);
      @(posedge pclk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      $display("test interrupts done");
      complete_run();
   end
endmodule
